// file: aie_add_exec.sv
// Execution of literal, file and pointer add instructions in four phases
// Functional notes
// RULE1: Literal add sums the 8-bit literal with the accumulator into it.
// RULE2: File add sums the accumulator and the addressed data-memory byte.
// RULE3: Destination bit 0 puts the sum in the accumulator, memory untouched.
// RULE4: Destination bit 1 writes the sum back to the addressed byte.
// RULE5: Access bit 0 resolves the file address in the access bank.
// RULE6: Access bit 1 uses the bank choice register to pick the bank.
// RULE7: Access 0, extended set on and address up to 5Fh: indexed offset.
// RULE8: Literal and file add update N, OV, C, DC and Z from the sum.
// RULE9: Pointer add decodes Q1, reads literal Q2, computes Q3, writes Q4.
// RULE10: Literal add decodes, reads, computes, writes accumulator in Q4.
// RULE11: Pointer add adds a 6-bit literal to the full pointer width.
// RULE12: Each instruction is one word and one four-phase cycle, no stall.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module aie_add_exec
  import aie_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int PTR_W  = 14
) (
  // Clock, reset and enable
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Instruction feed from the fetch unit
  input  wire logic [15:0]       instr_word,
  input  wire logic              instr_valid,
  output logic                   instr_ready,
  // Data memory port
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_rd,
  input  wire logic [7:0]        mem_rdata,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata,
  // Core state views
  output logic [1:0]             phase,
  output logic [7:0]             acc_value,
  output logic [FLG_W-1:0]       flags_value,
  // Avalon-MM register slave
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest
);

  // All state of the block
  // The first group travels with the instruction through its four phases,
  // the middle group is what software sees, the last group drives memory and answers the bus.
  // Keeping all of it in one record lets one enable freeze everything.
  typedef struct packed {
    aie_phase_t                   q;
    aie_op_t                      op;
    logic                         dest_file;
    logic [7:0]                   lit;
    logic [1:0]                   fsel;
    logic [7:0]                   res;
    logic [FLG_W-1:0]             fpend;
    logic [PTR_W-1:0]             psum;
    logic                         ext_en;
    logic [7:0]                   acc;
    logic [FLG_W-1:0]             flags;
    logic [5:0]                   bank;
    logic [NUM_PTR-1:0][PTR_W-1:0] ptr;
    logic [ADDR_W-1:0]            addr;
    logic                         rd;
    logic                         wr;
    logic [7:0]                   wdata;
    logic                         ack;
    logic [31:0]                  rdata;
  } aie_state_t;

  // Present and next state
  aie_state_t s_reg;
  aie_state_t s_next;

  // Decode, address and adder helpers
  logic              bus_req;
  logic [5:0]        dec_opc6;
  logic [7:0]        dec_opc8;
  logic [7:0]        dec_f;
  logic              dec_acc_sel;
  logic [ADDR_W-1:0] file_addr;
  logic [7:0]        opnd;
  logic [8:0]        sum9;
  logic [4:0]        nib;
  logic [FLG_W-1:0]  sum_flags;
  logic              is_lit;
  logic              is_file;
  logic              is_ptr;
  logic              idx_hit;
  logic              sgn_same;
  logic              sgn_flip;
  logic [PTR_W-1:0]  ptr_pick;
  logic [31:0]       ptr_word [NUM_PTR];

  // Instruction fields
  assign dec_opc8    = instr_word[15:8];
  assign dec_opc6    = instr_word[15:10];
  assign dec_f       = instr_word[7:0];
  assign dec_acc_sel = instr_word[ACCESS_BIT];
  assign bus_req     = avs_read | avs_write;

  // Opcode decode; pointer select 3 is not a pointer and stays a no-op
  assign is_lit  = (dec_opc8 == OPC_LIT_ADD);
  assign is_file = (dec_opc6 == OPC_FILE_ADD);
  assign is_ptr  = (dec_opc8 == OPC_PTR_ADD)
                   && (instr_word[7:6] != 2'b11);

  // Low file addresses fall in the literal offset window
  assign idx_hit = (dec_f <= IDX_LIMIT);

  // Readback words of the pointers, zero-extended to the bus width
  for (genvar g = 0; g < NUM_PTR; g++) begin : g_ptr_word
    assign ptr_word[g] = 32'(s_reg.ptr[g]);
  end

  // File address resolution
  // The bank and pointer are read from state in Q1, so a bus write that
  // lands in the same cycle only counts for the next instruction.
  always_comb begin
    file_addr = '0;
    if (dec_acc_sel) begin
      file_addr = ADDR_W'({s_reg.bank, dec_f});                   // [RULE6]
    end else if (s_reg.ext_en && idx_hit) begin
      file_addr = ADDR_W'(s_reg.ptr[IDX_PTR_SEL]
                          + PTR_W'(dec_f));                       // [RULE7]
    end else if (idx_hit) begin
      file_addr = ADDR_W'({ACC_LO_BANK, dec_f});                  // [RULE5]
    end else begin
      file_addr = ADDR_W'({ACC_HI_BANK, dec_f});                  // [RULE5]
    end
  end

  // Adder and its flags
  // Both operands are unsigned bytes; the ninth bit is the carry
  always_comb begin
    opnd = (s_reg.op == AIE_OP_FILE) ? mem_rdata : s_reg.lit;     // [RULE2]
    sum9 = {1'b0, s_reg.acc} + {1'b0, opnd};                      // [RULE1]
    // Digit carry comes out of the low nibble
    nib  = {1'b0, s_reg.acc[3:0]} + {1'b0, opnd[3:0]};
    sum_flags         = '0;
    sum_flags[FLG_C]  = sum9[8];                                  // [RULE8]
    sum_flags[FLG_DC] = nib[4];
    sum_flags[FLG_Z]  = (sum9[7:0] == 8'h00);
    sum_flags[FLG_N]  = sum9[7];
    sum_flags[FLG_OV] = sgn_same && sgn_flip;
  end

  // Sign tests for the signed wrap flag: equal-signed operands, sum flips
  assign sgn_same = (s_reg.acc[7] == opnd[7]);
  assign sgn_flip = (sum9[7] != s_reg.acc[7]);

  // Pointer picked for the add; select 3 never indexes past the last one
  always_comb begin
    ptr_pick = '0;
    if (s_reg.fsel < 2'(NUM_PTR)) begin
      ptr_pick = s_reg.ptr[s_reg.fsel];
    end
  end

  // Next-state logic: phase sequencer, execution and register bus
  // The phases run whether or not an instruction was taken, so the
  // instruction feed always finds Q1 once every four enabled cycles.
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.q)
      AIE_Q1: begin
        s_next.q   = AIE_Q2;
        s_next.op  = AIE_OP_NONE;
        // Strobes of the previous instruction already fell in Q2 and Q4; cleared again here
        s_next.wr  = 1'b0;
        s_next.rd  = 1'b0;
        if (instr_valid) begin
          // Latch the fields whatever the opcode
          s_next.lit       = dec_f;
          s_next.dest_file = instr_word[DEST_BIT];
          s_next.fsel      = instr_word[7:6];
          if (is_lit) begin
            s_next.op = AIE_OP_LIT;                               // [RULE10]
          end else if (is_file) begin
            s_next.op   = AIE_OP_FILE;
            s_next.addr = file_addr;
            s_next.rd   = 1'b1;                                   // [RULE2]
          end else if (is_ptr) begin
            s_next.op = AIE_OP_PTR;                               // [RULE9]
          end
        end
      end
      AIE_Q2: begin
        // Memory answers during Q3
        s_next.q  = AIE_Q3;
        s_next.rd = 1'b0;
      end
      AIE_Q3: begin
        s_next.q     = AIE_Q4;
        s_next.res   = sum9[7:0];
        s_next.fpend = sum_flags;
        // Pointer sum is formed for every op, kept only by pointer add
        s_next.psum  = ptr_pick
                       + PTR_W'(s_reg.lit[5:0]);                  // [RULE11]
        // File add with destination 1 writes memory during Q4
        if ((s_reg.op == AIE_OP_FILE) && s_reg.dest_file) begin
          s_next.wr    = 1'b1;                                    // [RULE4]
          s_next.wdata = sum9[7:0];
        end
      end
      AIE_Q4: begin
        // Memory write strobe falls as the cycle closes
        s_next.q  = AIE_Q1;                                       // [RULE12]
        s_next.wr = 1'b0;
      end
    endcase

    // Bus access: one wait cycle, then the answer
    // The answer is registered so readdata comes from flip-flops; the
    // price is one wait state on every transfer.
    s_next.ack = 1'b0;
    if (bus_req && !s_reg.ack) begin
      s_next.ack   = 1'b1;
      s_next.rdata = '0;
      // Unmapped offsets read as zero
      unique case (avs_address)
        REG_CTRL:  s_next.rdata[CTRL_EXT_BIT] = s_reg.ext_en;
        REG_ACC:   s_next.rdata[7:0]          = s_reg.acc;
        REG_FLAGS: s_next.rdata[FLG_W-1:0]    = s_reg.flags;
        REG_BANK:  s_next.rdata[5:0]          = s_reg.bank;
        REG_PTR0:  s_next.rdata               = ptr_word[0];
        REG_PTR1:  s_next.rdata               = ptr_word[1];
        REG_PTR2:  s_next.rdata               = ptr_word[2];
        default:   s_next.rdata               = '0;
      endcase
    end
    // A write lands at the edge where waitrequest is seen low
    if (avs_write && s_reg.ack) begin
      unique case (avs_address)
        REG_CTRL:  s_next.ext_en = avs_writedata[CTRL_EXT_BIT];
        REG_ACC:   s_next.acc    = avs_writedata[7:0];
        REG_FLAGS: s_next.flags  = avs_writedata[FLG_W-1:0];
        REG_BANK:  s_next.bank   = avs_writedata[5:0];
        REG_PTR0:  s_next.ptr[0] = avs_writedata[PTR_W-1:0];
        REG_PTR1:  s_next.ptr[1] = avs_writedata[PTR_W-1:0];
        REG_PTR2:  s_next.ptr[2] = avs_writedata[PTR_W-1:0];
        default:   s_next.ext_en = s_reg.ext_en;
      endcase
    end

    // Q4 write-back; the core wins over a bus write at the same edge
    // so that an instruction result is never lost to software.
    if (s_reg.q == AIE_Q4) begin
      // Only the instruction's own destination changes
      unique case (s_reg.op)
        AIE_OP_LIT: begin
          s_next.acc   = s_reg.res;                               // [RULE10]
          s_next.flags = s_reg.fpend;                             // [RULE8]
        end
        AIE_OP_FILE: begin
          if (!s_reg.dest_file) begin
            s_next.acc = s_reg.res;                               // [RULE3]
          end
          s_next.flags = s_reg.fpend;                             // [RULE8]
        end
        AIE_OP_PTR: begin
          s_next.ptr[s_reg.fsel] = s_reg.psum;                    // [RULE9]
        end
        AIE_OP_NONE: begin
          s_next.acc = s_next.acc;
        end
      endcase
    end
  end

  // State register, frozen while the enable is low
  // Reset clears the whole record, then loads the named reset values.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg       <= '0;
      s_reg.acc   <= ACC_RST;
      s_reg.flags <= FLAGS_RST;
      s_reg.bank  <= BANK_RST;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // Outputs
  // Memory strobes, data and views come straight from flip-flops;
  // only the two handshake outputs are combinational; while the enable
  // is low instr_ready falls and waitrequest stays high for a request.
  assign instr_ready     = clk_en && (s_reg.q == AIE_Q1);
  assign mem_addr        = s_reg.addr;
  assign mem_rd          = s_reg.rd;
  assign mem_wr          = s_reg.wr;
  assign mem_wdata       = s_reg.wdata;
  assign phase           = s_reg.q;
  assign acc_value       = s_reg.acc;
  assign flags_value     = s_reg.flags;
  assign avs_readdata    = s_reg.rdata;
  assign avs_waitrequest = bus_req && !(s_reg.ack && clk_en);

endmodule

// file: aie_add_exec_assertions.sv
// Port timing and arithmetic checks for the add execution block
`timescale 1ns/10ps
module aie_add_exec_assertions
  import aie_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // Clock, reset and enable
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              clk_en,
  // Instruction feed
  input wire logic [15:0]       instr_word,
  input wire logic              instr_valid,
  input wire logic              instr_ready,
  // Memory port and state views
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_rd,
  input wire logic [7:0]        mem_rdata,
  input wire logic              mem_wr,
  input wire logic [7:0]        mem_wdata,
  input wire logic [1:0]        phase,
  input wire logic [7:0]        acc_value,
  input wire logic [FLG_W-1:0]  flags_value
);
  logic       take;
  logic [1:0] ph_next;
  // Instruction take and the Gray step of the phase
  assign take    = clk_en && instr_ready && instr_valid;
  assign ph_next = {phase[0], ~phase[1]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_file; take && instr_word[15:10] == OPC_FILE_ADD; endsequence
  sequence s_lit; take && instr_word[15:8] == OPC_LIT_ADD; endsequence
  sequence s_ptr; take && instr_word[15:8] == OPC_PTR_ADD; endsequence
  a_phase_step: assert property (
    clk_en |=> phase == $past(ph_next))
    else $error("phase out of order");
  a_hold_frozen: assert property (
    !clk_en |=> $stable(phase) && $stable(acc_value)
                && $stable(flags_value))
    else $error("state moved while frozen");
  a_file_read: assert property (
    s_file |=> mem_rd && !mem_wr ##1 !mem_rd)
    else $error("file read strobe wrong");
  a_dest_mem: assert property (
    (s_file ##0 instr_word[DEST_BIT]) |-> ##3 mem_wr)
    else $error("no write back");
  a_dest_acc: assert property (
    (s_file ##0 !instr_word[DEST_BIT]) |=> !mem_wr [*3])
    else $error("memory written for acc dest");
  a_wdata_sum: assert property (
    mem_wr |-> mem_wdata == 8'(acc_value + $past(mem_rdata)))
    else $error("write data not the sum");
  a_access_hi: assert property (
    (s_file ##0 (!instr_word[ACCESS_BIT] && instr_word[7:0] > IDX_LIMIT))
    |=> mem_addr == {ACC_HI_BANK, $past(instr_word[7:0])})
    else $error("access bank address");
  a_lit_sum: assert property (
    s_lit |-> ##4 acc_value
      == 8'($past(acc_value, 4) + $past(instr_word[7:0], 4)))
    else $error("literal sum wrong");
  a_lit_late: assert property (
    s_lit |=> $stable(acc_value) [*3])
    else $error("acc written before Q4");
  a_lit_flags: assert property (
    s_lit |-> ##4 flags_value[FLG_Z] == (acc_value == 8'h00)
      && flags_value[FLG_N] == acc_value[7])
    else $error("zero or sign flag wrong");
  a_ptr_quiet: assert property (
    s_ptr |=> (!mem_rd && !mem_wr && $stable(flags_value)) [*3])
    else $error("pointer add touched memory or flags");
endmodule
bind aie_add_exec aie_add_exec_assertions #(.ADDR_W(ADDR_W))
  i_aie_add_exec_assertions (.*);

// file: aie_add_exec_tb_top.sv
// Self-checking bench for the add execution block
`timescale 1ns/10ps
module aie_add_exec_tb_top
  import aie_pkg::*;
();
  localparam logic [15:0] CORNER [8] = '{16'h0F00, 16'h0F7F, 16'h0F01,
    16'hE8BF, 16'hE8C5, 16'h0B12, 16'h245F, 16'h2660};
  logic        clk_sys, instr_ready, mem_rd, mem_wr, avs_waitrequest, ext;
  logic        rst_n = 1'b0, clk_en = 1'b1, instr_valid = 1'b0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [15:0] instr_word = 16'h0000, w;
  logic [13:0] mem_addr, ea, ptr [3];
  logic [7:0]  mem_rdata, mem_wdata, acc_value, acc = 8'h00, old, emem;
  logic [4:0]  flags_value, flg = 5'h00, avs_address = 5'h00;
  logic [1:0]  phase;
  logic [5:0]  bank;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  int          mismatches = 0, cmp_count = 0, cyc = 0, j;
  aie_add_exec i_aie_add_exec (.*);
  aie_mem_model i_aie_mem_model (.*);
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Present a word in Q1, then wait out the cycle until write-back landed
  task automatic issue(input logic [15:0] iw);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (phase !== AIE_Q4 && n < 9);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= iw;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Sum and flags {N, OV, Z, DC, C}
  function automatic logic [12:0] fadd(input logic [7:0] a, b);
    logic [8:0] s;
    s = a + b;
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
            (a[3:0] + b[3:0]) > 5'h0F, s[8], s[7:0]};
  endfunction
  // Data address of a file operand
  function automatic logic [13:0] ea_of(input logic a, input logic [7:0] f);
    if (a) return {bank, f};
    if (f <= IDX_LIMIT) return ext ? 14'(ptr[2] + f) : {ACC_LO_BANK, f};
    return {ACC_HI_BANK, f};
  endfunction
  function automatic logic [15:0] rand_word();
    logic [15:0] r;
    r = 16'($urandom);
    case (r[15:14])
      2'h0: return {OPC_LIT_ADD, r[7:0]};
      2'h1: return {OPC_PTR_ADD, 2'(r[9:8] % 3), r[5:0]};
      default: return {OPC_FILE_ADD, r[9:0]};
    endcase
  endfunction
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop;
    end
  end
  // Main sequence
  initial begin
    void'($urandom(87));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    ptr[0] = 14'($urandom);
    ptr[1] = 14'($urandom);
    ptr[2] = 14'h3FFF;
    for (j = 0; j < 3; j++) bus(1'b1, 5'(REG_PTR0 + 4 * j), 32'(ptr[j]), q);
    for (int i = 0; i < 64; i++) begin
      ext = 1'($urandom);
      bank = 6'($urandom);
      bus(1'b1, REG_CTRL, 32'(ext), q);
      bus(1'b1, REG_BANK, 32'(bank), q);
      w = i < 8 ? CORNER[i] : rand_word();
      ea = ea_of(w[ACCESS_BIT], w[7:0]);
      old = i_aie_mem_model.mem[ea];
      issue(w);
      emem = old;
      if (w[15:8] == OPC_LIT_ADD) {flg, acc} = fadd(acc, w[7:0]);
      if (w[15:10] == OPC_FILE_ADD) begin
        {flg, emem} = fadd(acc, old);
        if (!w[DEST_BIT]) begin
          acc = emem;
          emem = old;
        end
      end
      if (w[15:8] == OPC_PTR_ADD && w[7:6] != 2'h3) ptr[w[7:6]] += w[5:0];
      chk(acc_value, acc);
      chk(flags_value, flg);
      chk(i_aie_mem_model.mem[ea], emem);
      j = $urandom % 3;
      bus(1'b0, 5'(REG_PTR0 + 4 * j), 32'h0, q);
      chk(q, 32'(ptr[j]));
      if (i == 32) begin
        clk_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b1;
      end
    end
    bus(1'b0, REG_ACC, 32'h0, q);
    chk(q, 32'(acc));
    bus(1'b0, REG_BANK, 32'h0, q);
    chk(q, 32'(bank));
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'(ext));
    bus(1'b0, REG_FLAGS, 32'h0, q);
    chk(q, 32'(flg));
    report_and_stop;
  end
endmodule

// file: aie_mem_model.sv
// Data memory model on the far side of the add execution block
`timescale 1ns/10ps
module aie_mem_model #(
  parameter int ADDR_W = 14
) (
  // Clock
  input  wire logic              clk_sys,
  // Memory port
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic [7:0]        mem_wdata,
  output logic      [7:0]        mem_rdata
);
  logic [7:0] mem [2**ADDR_W];
  // Read data one cycle after the strobe, scrambled when not asked for
  always @(posedge clk_sys) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
  // Preload a spread of values
  initial begin
    mem_rdata = 8'h00;
    foreach (mem[i]) mem[i] = 8'(i * 37);
  end
endmodule

// file: aie_pkg.sv
// Constants for the add-instruction execution block
package aie_pkg;

  // Opcode fields of the 16-bit instruction word
  localparam logic [7:0] OPC_LIT_ADD  = 8'h0F;
  localparam logic [5:0] OPC_FILE_ADD = 6'h09;
  localparam logic [7:0] OPC_PTR_ADD  = 8'hE8;
  localparam int         DEST_BIT     = 9;
  localparam int         ACCESS_BIT   = 8;

  // Addressing constants
  localparam logic [7:0] IDX_LIMIT    = 8'h5F;
  localparam logic [5:0] ACC_LO_BANK  = 6'h00;
  localparam logic [5:0] ACC_HI_BANK  = 6'h3F;
  localparam logic [1:0] IDX_PTR_SEL  = 2'h2;
  localparam int         NUM_PTR      = 3;

  // Flag bit positions
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;
  localparam int FLG_W  = 5;

  // Register byte offsets on the bus
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_ACC   = 5'h04;
  localparam logic [4:0] REG_FLAGS = 5'h08;
  localparam logic [4:0] REG_BANK  = 5'h0C;
  localparam logic [4:0] REG_PTR0  = 5'h10;
  localparam logic [4:0] REG_PTR1  = 5'h14;
  localparam logic [4:0] REG_PTR2  = 5'h18;
  localparam int         CTRL_EXT_BIT = 0;

  // Reset values
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [5:0] BANK_RST  = 6'h00;

  // Quarter phases, Gray coded
  typedef enum logic [1:0] {
    AIE_Q1 = 2'b00,
    AIE_Q2 = 2'b01,
    AIE_Q3 = 2'b11,
    AIE_Q4 = 2'b10
  } aie_phase_t;

  // Instruction kinds held through one cycle
  typedef enum logic [1:0] {
    AIE_OP_NONE = 2'b00,
    AIE_OP_LIT  = 2'b01,
    AIE_OP_FILE = 2'b11,
    AIE_OP_PTR  = 2'b10
  } aie_op_t;

endpackage
